/* rtl/asrc_ctrl.sv */
// Host controller driving a 1M x 16 asynchronous static memory
`timescale 1ns/1ps
`default_nettype none

module asrc_ctrl #(
	parameter int POWER_WAIT = asrc_pkg::POWER_WAIT_CYC
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// User request port
	input wire logic req_valid,
	input wire asrc_pkg::asrc_req_type req,
	output logic req_ready,
	output logic rd_valid,
	output logic [asrc_pkg::DATA_W-1:0] rd_data,
	// Retention entry: deselected and idle
	input wire logic retain_req,
	output logic retain_ok,
	// Memory pins
	output asrc_pkg::asrc_pins_type pins,
	input wire logic [asrc_pkg::DATA_W-1:0] data_in,
	output logic [asrc_pkg::DATA_W-1:0] data_out,
	output logic [asrc_pkg::DATA_W-1:0] data_oe
);

	// ****************************************
	// State
	// ****************************************
	asrc_pkg::asrc_state_type state_q, state_d;
	logic [asrc_pkg::CNT_W-1:0] cnt_q, cnt_d;
	logic [24:0] pwr_q, pwr_d;
	asrc_pkg::asrc_pins_type pins_q, pins_d;
	logic [asrc_pkg::DATA_W-1:0] dout_q, dout_d;
	logic [asrc_pkg::DATA_W-1:0] doe_q, doe_d;
	logic [asrc_pkg::DATA_W-1:0] rdat_q, rdat_d;
	logic rvld_q, rvld_d;
	logic [asrc_pkg::DATA_W-1:0] sync1_q, sync2_q;
	logic [1:0] lanes_q, lanes_d;

	function automatic logic [asrc_pkg::DATA_W-1:0] lane_mask(
		input logic [1:0] en);
		return {{asrc_pkg::LANE_W{en[1]}}, {asrc_pkg::LANE_W{en[0]}}};
	endfunction

	function automatic logic [asrc_pkg::CNT_W-1:0] cyc(input int n);
		return asrc_pkg::CNT_W'(n - 1);
	endfunction

	// Idle pins: deselected, strobe and drive enable high
	function automatic asrc_pkg::asrc_pins_type idle_pins(
		input logic [asrc_pkg::ADDR_W-1:0] a);
		asrc_pkg::asrc_pins_type p;
		p.select_active_low = 1'b1;
		p.select_active_high = 1'b0;
		p.write_strobe_n = 1'b1;
		p.output_drive_n = 1'b1;
		p.low_byte_lane_n = 1'b1;
		p.high_byte_lane_n = 1'b1;
		p.addr = a;
		return p;
	endfunction

	// ****************************************
	// Input synchroniser
	// ****************************************
	always_ff @(posedge sys_clk) begin
		sync1_q <= data_in;
		sync2_q <= sync1_q;
	end

	// ****************************************
	// Sequencer
	// ****************************************
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		pwr_d = pwr_q;
		pins_d = pins_q;
		dout_d = dout_q;
		doe_d = doe_q;
		rdat_d = rdat_q;
		rvld_d = 1'b0;
		lanes_d = lanes_q;
		unique case (state_q)
			asrc_pkg::ST_POWER: begin
				// Nothing reaches the memory until supply has settled
				if (pwr_q == 25'(POWER_WAIT - 1)) begin
					state_d = asrc_pkg::ST_IDLE;
				end else begin
					pwr_d = pwr_q + 25'd1;
				end
			end
			asrc_pkg::ST_IDLE: begin
				pins_d = idle_pins(pins_q.addr);
				doe_d = '0;
				if (req_valid && !retain_req && req.lane_en != 2'b00) begin
					lanes_d = req.lane_en;
					// Address, select and lanes together: no setup needed
					pins_d.addr = req.addr;
					pins_d.select_active_low = 1'b0;
					pins_d.select_active_high = 1'b1;
					pins_d.low_byte_lane_n = ~req.lane_en[0];
					pins_d.high_byte_lane_n = ~req.lane_en[1];
					if (req.write) begin
						// Drive enable stays high; only enabled lanes driven
						pins_d.write_strobe_n = 1'b0;
						dout_d = req.wdata;
						doe_d = lane_mask(req.lane_en);
						cnt_d = cyc(asrc_pkg::WR_LOW_CYC);
						state_d = asrc_pkg::ST_WRITE;
					end else begin
						pins_d.output_drive_n = 1'b0;
						cnt_d = cyc(asrc_pkg::RD_WAIT_CYC);
						state_d = asrc_pkg::ST_READ;
					end
				end
			end
			asrc_pkg::ST_WRITE: begin
				// Address, lanes and data held to the ending edge
				if (cnt_q == '0) begin
					// Strobe alone ends the write
					pins_d.write_strobe_n = 1'b1;
					state_d = asrc_pkg::ST_WEND;
				end else begin
					cnt_d = cnt_q - 1'b1;
				end
			end
			asrc_pkg::ST_WEND: begin
				// Data and address kept one more cycle past the end
				pins_d = idle_pins(pins_q.addr);
				doe_d = '0;
				state_d = asrc_pkg::ST_IDLE;
			end
			asrc_pkg::ST_READ: begin
				if (cnt_q == '0) begin
					// Only enabled lanes are sampled
					rdat_d = sync2_q & lane_mask(lanes_q);
					rvld_d = 1'b1;
					pins_d = idle_pins(pins_q.addr);
					cnt_d = cyc(asrc_pkg::TURN_CYC);
					state_d = asrc_pkg::ST_TURN;
				end else begin
					cnt_d = cnt_q - 1'b1;
				end
			end
			asrc_pkg::ST_TURN: begin
				// Let the memory float before we may drive again
				if (cnt_q == '0) begin
					state_d = asrc_pkg::ST_IDLE;
				end else begin
					cnt_d = cnt_q - 1'b1;
				end
			end
			default: begin
				state_d = asrc_pkg::ST_IDLE;
				pins_d = idle_pins(pins_q.addr);
				doe_d = '0;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state_q <= asrc_pkg::ST_POWER;
			cnt_q <= '0;
			pwr_q <= '0;
			pins_q <= '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, '0};
			dout_q <= '0;
			doe_q <= '0;
			rdat_q <= '0;
			rvld_q <= 1'b0;
			lanes_q <= '0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			pwr_q <= pwr_d;
			pins_q <= pins_d;
			dout_q <= dout_d;
			doe_q <= doe_d;
			rdat_q <= rdat_d;
			rvld_q <= rvld_d;
			lanes_q <= lanes_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// Select and strobe never release in the same cycle, so the device
	// outputs can't glitch on at write end
	assign pins = pins_q;
	assign data_out = dout_q;
	assign data_oe = doe_q;
	assign rd_data = rdat_q;
	assign rd_valid = rvld_q;
	assign req_ready = (state_q == asrc_pkg::ST_IDLE) && !retain_req;
	assign retain_ok = (state_q == asrc_pkg::ST_IDLE) && retain_req
		&& pins_q.select_active_low;

endmodule

`default_nettype wire

/* rtl/asrc_pkg.sv */
// Package: constants and carrier types for the async SRAM host controller
package asrc_pkg;

	// ****************************************
	// Geometry
	// ****************************************
	localparam int ADDR_W = 20;
	localparam int DATA_W = 16;
	localparam int LANE_W = 8;

	// ****************************************
	// Timing (ns / us as printed) and cycle counts at 100 MHz
	// ****************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int CLK_MHZ = 100;
	// Speed grade select: 1 = fast (10 ns), 0 = slow (15 ns)
	localparam bit FAST_GRADE = 1'b0;
	localparam int ADDR_TO_DATA_DELAY_NS = FAST_GRADE ? 10 : 15;
	localparam int OUTPUT_DRIVE_TO_DATA_DELAY_NS = FAST_GRADE ? 5 : 8;
	localparam int LANE_ENABLE_TO_DATA_DELAY_NS = FAST_GRADE ? 5 : 8;
	localparam int LANE_DISABLE_TO_FLOAT_NS = FAST_GRADE ? 6 : 8;
	localparam int ADDR_SETUP_TO_WRITE_END_NS = FAST_GRADE ? 7 : 12;
	localparam int LANE_ENABLE_TO_WRITE_END_NS = FAST_GRADE ? 7 : 12;
	localparam int DATA_SETUP_TO_WRITE_END_NS = FAST_GRADE ? 5 : 8;
	localparam int STROBE_LOW_TO_FLOAT_NS = FAST_GRADE ? 5 : 8;
	localparam int ADDR_HOLD_AFTER_WRITE_END_NS = 0;
	localparam int DATA_HOLD_AFTER_WRITE_END_NS = 0;
	localparam int ADDR_SETUP_TO_WRITE_START_NS = 0;
	localparam int DESELECT_TO_RETENTION_NS = 0;
	localparam int POWER_TO_FIRST_ACCESS_US = 100;

	// Least times round up
	function automatic int ns_to_cyc(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	function automatic int max2(input int a, input int b);
		return (a > b) ? a : b;
	endfunction

	// Write strobe low time covers address, lane, data setup and turn-off
	localparam int WR_LOW_CYC = max2(max2(
		ns_to_cyc(ADDR_SETUP_TO_WRITE_END_NS),
		ns_to_cyc(LANE_ENABLE_TO_WRITE_END_NS)),
		ns_to_cyc(STROBE_LOW_TO_FLOAT_NS + DATA_SETUP_TO_WRITE_END_NS));
	// Read wait: worst of address, output-drive and lane access, plus two
	// cycles for the two-stage input synchroniser
	localparam int RD_WAIT_CYC = max2(max2(
		ns_to_cyc(ADDR_TO_DATA_DELAY_NS),
		ns_to_cyc(OUTPUT_DRIVE_TO_DATA_DELAY_NS)),
		ns_to_cyc(LANE_ENABLE_TO_DATA_DELAY_NS)) + 2;
	// Bus turn-around after a read before driving data again
	localparam int TURN_CYC = ns_to_cyc(LANE_DISABLE_TO_FLOAT_NS);
	localparam int POWER_WAIT_CYC = POWER_TO_FIRST_ACCESS_US * CLK_MHZ;
	localparam int CNT_W = 16;

	// ****************************************
	// Carrier types
	// ****************************************
	typedef struct packed {
		logic write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [1:0] lane_en;
	} asrc_req_type;

	typedef struct packed {
		logic select_active_low;
		logic select_active_high;
		logic write_strobe_n;
		logic output_drive_n;
		logic low_byte_lane_n;
		logic high_byte_lane_n;
		logic [ADDR_W-1:0] addr;
	} asrc_pins_type;

	typedef enum logic [5:0] {
		ST_POWER = 6'b000001,
		ST_IDLE = 6'b000010,
		ST_WRITE = 6'b000100,
		ST_WEND = 6'b001000,
		ST_READ = 6'b010000,
		ST_TURN = 6'b100000
	} asrc_state_type;

endpackage

/* verification/asrc_ctrl_props.sv */
// Checker of the controller pin timing and handshake
`timescale 1ns/1ps
`default_nettype none
module asrc_ctrl_props #(
	parameter int POWER_WAIT = 4
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// User side
	input wire logic req_valid,
	input wire asrc_pkg::asrc_req_type req,
	input wire logic req_ready,
	input wire logic rd_valid,
	input wire logic retain_ok,
	// Memory side
	input wire asrc_pkg::asrc_pins_type pins,
	input wire logic [asrc_pkg::DATA_W-1:0] data_out,
	input wire logic [asrc_pkg::DATA_W-1:0] data_oe
);
	logic sel;
	logic [15:0] up_q;
	assign sel = !pins.select_active_low && pins.select_active_high;
	// Saturates so a long run never wraps into a false early ready
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			up_q <= 16'h0000;
		end else if (up_q != 16'hFFFF) begin
			up_q <= up_q + 16'h0001;
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	AST_IDLE_AFTER_RESET: assert property ($fell(reset) |-> !sel
		&& pins.write_strobe_n && data_oe == 16'h0000) else $error("not idle");
	AST_POWER_WAIT: assert property (req_ready |-> up_q >= POWER_WAIT)
		else $error("ready too early");
	AST_READ_STROBE: assert property (!pins.output_drive_n |->
		pins.write_strobe_n) else $error("strobe low in read");
	AST_READ_FLOAT: assert property (!pins.output_drive_n |->
		data_oe == 16'h0000) else $error("host drives in read");
	AST_READ_LANE: assert property (!pins.output_drive_n |-> sel &&
		!(pins.low_byte_lane_n && pins.high_byte_lane_n)) else $error("read lanes");
	AST_WRITE_START: assert property (!pins.write_strobe_n |-> sel
		&& pins.output_drive_n) else $error("write not selected");
	AST_WRITE_LANES: assert property (!pins.write_strobe_n |-> data_oe ==
		{{8{!pins.high_byte_lane_n}}, {8{!pins.low_byte_lane_n}}})
		else $error("write lanes");
	AST_WRITE_LEN: assert property ($fell(pins.write_strobe_n) |->
		!pins.write_strobe_n [*2] ##1 pins.write_strobe_n) else $error("strobe len");
	AST_WRITE_END_HOLD: assert property ($rose(pins.write_strobe_n) |-> sel
		&& $stable(pins.addr) && $stable(data_out) && data_oe != 16'h0000)
		else $error("hold at write end");
	AST_ADDR_STABLE: assert property (sel && $past(sel) |->
		$stable(pins.addr)) else $error("addr moved");
	AST_READ_TIME: assert property (req_valid && req_ready && !req.write
		&& req.lane_en != 2'b00 |-> ##5 rd_valid) else $error("read late");
	AST_RETAIN: assert property (retain_ok |-> !sel)
		else $error("retain selected");
endmodule
bind asrc_ctrl asrc_ctrl_props #(.POWER_WAIT(POWER_WAIT)) i_asrc_ctrl_props (
	.sys_clk(sys_clk), .reset(reset), .req_valid(req_valid), .req(req),
	.req_ready(req_ready), .rd_valid(rd_valid), .retain_ok(retain_ok),
	.pins(pins), .data_out(data_out), .data_oe(data_oe));
`default_nettype wire

/* verification/asrc_ctrl_test.sv */
// Self-checking bench of the async memory controller
`timescale 1ns/1ps
`default_nettype none
module asrc_ctrl_test;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic req_valid = 1'b0;
	asrc_pkg::asrc_req_type req = '0;
	logic retain_req = 1'b0;
	logic req_ready;
	logic rd_valid;
	logic retain_ok;
	logic [15:0] rd_data;
	logic [15:0] data_in;
	logic [15:0] data_out;
	logic [15:0] data_oe;
	asrc_pkg::asrc_pins_type pins;
	int error_cnt = 0;
	int total_checks = 0;
	always #5 sys_clk = ~sys_clk;
	asrc_ctrl #(.POWER_WAIT(4)) i_asrc_ctrl (.sys_clk(sys_clk), .reset(reset),
		.req_valid(req_valid), .req(req), .req_ready(req_ready),
		.rd_valid(rd_valid), .rd_data(rd_data), .retain_req(retain_req),
		.retain_ok(retain_ok), .pins(pins), .data_in(data_in),
		.data_out(data_out), .data_oe(data_oe));
	asrc_sram_model i_asrc_sram_model (.sys_clk(sys_clk), .pins(pins),
		.data_out(data_out), .data_oe(data_oe), .data_in(data_in));
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task end_sim;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// Held until the edge where ready is seen high
	task do_req(input logic w, input logic [19:0] a, input logic [15:0] d,
		input logic [1:0] le);
		int n;
		n = 0;
		@(posedge sys_clk);
		req_valid <= 1'b1;
		req <= {w, a, d, le};
		@(negedge sys_clk);
		while (req_ready !== 1'b1 && n < 50) begin
			@(negedge sys_clk);
			n++;
		end
		chk("req_ready", 16'h0001, {15'h0000, req_ready});
		@(posedge sys_clk);
		req_valid <= 1'b0;
	endtask
	task do_read(input logic [19:0] a, input logic [1:0] le,
		output logic [15:0] q);
		int n;
		n = 0;
		do_req(1'b0, a, 16'h0000, le);
		do begin
			@(negedge sys_clk);
			n++;
		end while (rd_valid !== 1'b1 && n < 20);
		chk("rd_valid", 16'h0001, {15'h0000, rd_valid});
		q = rd_data;
	endtask
	// A request with no lane enabled must never be taken
	task t_refuse;
		logic [15:0] q;
		@(posedge sys_clk);
		req_valid <= 1'b1;
		req <= {1'b1, 20'h00001, 16'hBEEF, 2'b00};
		repeat (4) @(posedge sys_clk);
		@(negedge sys_clk);
		chk("write_strobe_n", 16'h0001, {15'h0000, pins.write_strobe_n});
		chk("select_active_low", 16'h0001, {15'h0000, pins.select_active_low});
		@(posedge sys_clk);
		req_valid <= 1'b0;
		do_read(20'h00001, 2'b11, q);
		chk("rd_data refused", 16'h0000, q);
	endtask
	task t_power;
		chk("req_ready", 16'h0000, {15'h0000, req_ready});
		chk("select_active_low", 16'h0001, {15'h0000, pins.select_active_low});
		chk("data_oe", 16'h0000, data_oe);
	endtask
	task t_word;
		logic [15:0] q;
		do_req(1'b1, 20'h00000, 16'hA55A, 2'b11);
		do_req(1'b1, 20'hFFFFF, 16'h1234, 2'b11);
		do_read(20'h00000, 2'b11, q);
		chk("rd_data low addr", 16'hA55A, q);
		do_read(20'hFFFFF, 2'b11, q);
		chk("rd_data high addr", 16'h1234, q);
	endtask
	task t_lanes;
		logic [15:0] q;
		do_req(1'b1, 20'h00000, 16'hFFC3, 2'b01);
		do_req(1'b1, 20'h00000, 16'h7E00, 2'b10);
		do_read(20'h00000, 2'b11, q);
		chk("rd_data lanes", 16'h7EC3, q);
		do_read(20'h00000, 2'b01, q);
		chk("rd_data low lane", 16'h00C3, q);
		do_read(20'h00000, 2'b10, q);
		chk("rd_data high lane", 16'h7E00, q);
	endtask
	task t_retain;
		@(posedge sys_clk);
		retain_req <= 1'b1;
		// A pending read must stay blocked while retention is asked for
		req_valid <= 1'b1;
		req <= {1'b0, 20'h00000, 16'h0000, 2'b11};
		repeat (8) @(posedge sys_clk);
		@(negedge sys_clk);
		chk("retain_ok", 16'h0001, {15'h0000, retain_ok});
		chk("req_ready", 16'h0000, {15'h0000, req_ready});
		chk("select_active_high", 16'h0000, {15'h0000, pins.select_active_high});
		chk("rd_valid", 16'h0000, {15'h0000, rd_valid});
		@(posedge sys_clk);
		retain_req <= 1'b0;
		req_valid <= 1'b0;
	endtask
	initial begin
		repeat (10) @(posedge sys_clk);
		reset <= 1'b0;
		@(negedge sys_clk);
		t_power;
		t_word;
		t_lanes;
		t_refuse;
		t_retain;
		end_sim;
	end
	// The whole sequence needs well under two thousand cycles
	initial begin
		#100000;
		error_cnt++;
		end_sim;
	end
endmodule
`default_nettype wire

/* verification/asrc_sram_model.sv */
// Behavioural model of the asynchronous static memory
`timescale 1ns/1ps
`default_nettype none
module asrc_sram_model (
	// Clock for the behavioural timing
	input wire logic sys_clk,
	// Device pins
	input wire asrc_pkg::asrc_pins_type pins,
	input wire logic [15:0] data_out,
	input wire logic [15:0] data_oe,
	output logic [15:0] data_in
);
	logic [15:0] mem [logic [19:0]];
	logic [15:0] junk_q = 16'h5AC3;
	logic [15:0] word_q = 16'h0000;
	logic [15:0] old;
	logic [15:0] bus;
	logic [15:0] drv;
	logic [1:0] lane;
	logic sel;
	logic rd;
	logic rd_q = 1'b0;
	assign sel = !pins.select_active_low && pins.select_active_high;
	assign lane = ~{pins.high_byte_lane_n, pins.low_byte_lane_n};
	assign rd = sel && pins.write_strobe_n && !pins.output_drive_n;
	// Floating lines flip every cycle so a stale value never matches
	assign bus = (data_oe & data_out) | (~data_oe & junk_q);
	assign drv = {lane[1] ? word_q[15:8] : junk_q[15:8],
		lane[0] ? word_q[7:0] : junk_q[7:0]};
	// Data only a cycle after the read opens, no earlier than the fast-grade 10 ns access time
	assign data_in = (rd && rd_q) ?
		((data_oe & data_out) | (~data_oe & drv)) : bus;
	always @(posedge sys_clk) begin
		junk_q <= ~junk_q;
		rd_q <= rd;
		old = mem.exists(pins.addr) ? mem[pins.addr] : 16'h0000;
		word_q <= old;
		if (sel && !pins.write_strobe_n && lane != 2'b00) begin
			mem[pins.addr] = {lane[1] ? bus[15:8] : old[15:8],
				lane[0] ? bus[7:0] : old[7:0]};
		end
	end
endmodule
`default_nettype wire
